// >>> hdl/cmm_pkg.sv
/*
  Package for the controller mode manager: mode encodings, startup word fields,
  parameter-store offset and tool command codes.
  Assumes a single 10 MHz clock domain and a synchronous active-high reset.
*/
package cmm_pkg;
  typedef enum logic [2:0] {
    CMM_EDIT = 3'h1,
    CMM_DEBUG = 3'h2,
    CMM_RUN = 3'h4
  } cmm_mode_t;

  localparam logic [15:0] CMM_STARTUP_WORD_ADDR = 16'h19C8;
  localparam logic [15:0] CMM_STARTUP_WORD_RESET = 16'h0000;
  localparam int CMM_UPPER_LSB = 8;
  localparam int CMM_LOWER_LSB = 0;
  localparam logic [7:0] CMM_UP_SWITCH = 8'h00;
  localparam logic [7:0] CMM_UP_PREVIOUS = 8'h01;
  localparam logic [7:0] CMM_UP_LOWER = 8'h02;
  localparam logic [7:0] CMM_LO_EDIT = 8'h00;
  localparam logic [7:0] CMM_LO_DEBUG = 8'h01;
  localparam logic [7:0] CMM_LO_RUN = 8'h02;

  // Tool command codes
  localparam logic [2:0] CMM_CMD_MONITOR = 3'h0;
  localparam logic [2:0] CMM_CMD_FORCE = 3'h1;
  localparam logic [2:0] CMM_CMD_VALUE = 3'h2;
  localparam logic [2:0] CMM_CMD_EDIT = 3'h3;
  localparam logic [2:0] CMM_CMD_PARAM = 3'h4;
  localparam logic [2:0] CMM_CMD_PROGRAM = 3'h5;

  localparam int CMM_IO_WORDS = 16;
  localparam logic [CMM_IO_WORDS-1:0] CMM_RETAIN_MASK = 16'hFF00;
  localparam logic [3:0] CMM_CLEAR_LAST = 4'hF;
endpackage

// >>> hdl/cmm_startup_decode.sv
/*
  Startup mode decoder: turns the startup word, programmer presence and switch
  into the mode to enter after power-on.
  Assumes stable inputs while the power-on sequence samples it.
*/
`timescale 1ns/1ns
module cmm_startup_decode
  import cmm_pkg::*;
(
  input wire logic [15:0] i_word,
  input wire logic i_prog_present,
  input wire cmm_mode_t i_switch_mode,
  input wire cmm_mode_t i_retained_mode,
  output cmm_mode_t o_mode
);
  function automatic cmm_mode_t lower_decode(input logic [7:0] f);
    unique case (f)
      CMM_LO_EDIT: lower_decode = CMM_EDIT;
      CMM_LO_DEBUG: lower_decode = CMM_DEBUG;
      default: lower_decode = CMM_RUN; // Unused codes fall to run
    endcase
  endfunction

  logic [7:0] upper;
  assign upper = i_word[CMM_UPPER_LSB +: 8];

  always_comb begin
    if (upper == CMM_UP_PREVIOUS) begin
      o_mode = i_retained_mode;
    end else if (upper == CMM_UP_LOWER) begin
      o_mode = lower_decode(i_word[CMM_LOWER_LSB +: 8]);
    end else if (i_prog_present) begin
      o_mode = i_switch_mode;
    end else begin
      o_mode = CMM_RUN;
    end
  end
endmodule

// >>> hdl/cmm_mode_manager.sv
/*
  Controller mode manager: chooses edit, debug-run or run mode, gates program
  execution and tool access, clears non-retained I/O memory at power-on.
  Assumes i_srst is the power-on reset and that retained mode survives it.
*/
// Summary of operation
// - Edit mode never executes the user program.
// - I/O refresh keeps running in edit mode.
// - Edit mode accepts parameter, program and forcing commands from the tool.
// - Debug-run executes the program and allows monitoring, forcing and value changes.
// - Run mode executes the program and rejects edits, forcing and value changes.
// - The parameter store is written only by the tool, never by the program.
// - Power-on parameters latch at startup; continuous ones follow live.
// - Power-on clears non-retained I/O words and keeps retained ones.
// - The communications selector picks default or stored serial settings.
// - Upper field 00 uses the programmer switch if present, else run.
// - Upper field 01 restores the mode held before power loss.
// - Upper field 02 takes the mode from the lower field.
// - Lower field 00, 01, 02 gives edit, debug-run, run.
// - Default word with no programmer starts straight in run mode.
// - Main program runs cyclically; interrupt programs only on their interrupt.
`timescale 1ns/1ns
module cmm_mode_manager
  import cmm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_prog_present,
  input wire cmm_mode_t i_switch_mode,
  input wire logic i_mode_req,
  input wire cmm_mode_t i_mode_req_val,
  input wire logic i_tool_valid,
  input wire logic [2:0] i_tool_cmd,
  input wire logic i_prog_pstore_wr,
  input wire logic [15:0] i_pstore_wdata,
  input wire logic i_comm_select,
  input wire logic i_irq,
  input wire logic i_cycle_tick,
  output cmm_mode_t o_mode,
  output logic o_exec_main,
  output logic o_exec_irq,
  output logic o_io_refresh,
  output logic o_tool_accept,
  output logic o_tool_reject,
  output logic o_pstore_we,
  output logic [15:0] o_startup_mode_setting,
  output logic o_use_stored_comm,
  output logic o_init_busy,
  output logic [3:0] o_clear_word,
  output logic o_clear_we
);
  logic prog_s1, prog_s2, comm_s1, comm_s2, irq_s1, irq_s2;
  logic req_s1, req_s2;
  cmm_mode_t switch_s1, switch_s2, req_val_s1, req_val_s2;
  logic tool_pstore_wr;
  logic [15:0] startup_mode_setting;
  cmm_mode_t mode, retained_mode, startup_mode;
  logic init_busy;
  logic [3:0] clr_idx;
  logic running;

  // Pins from the programmer pass two flops first
  always_ff @(posedge i_clk) begin
    prog_s1 <= i_prog_present;
    prog_s2 <= prog_s1;
    comm_s1 <= i_comm_select;
    comm_s2 <= comm_s1;
    irq_s1 <= i_irq;
    irq_s2 <= irq_s1;
    req_s1 <= i_mode_req;
    req_s2 <= req_s1;
    // Switch setting and requested mode are programmer pins as well
    switch_s1 <= i_switch_mode;
    switch_s2 <= switch_s1;
    req_val_s1 <= i_mode_req_val;
    req_val_s2 <= req_val_s1;
  end

  cmm_startup_decode u_dec (
    .i_word(startup_mode_setting),
    .i_prog_present(prog_s2),
    .i_switch_mode(switch_s2),
    .i_retained_mode(retained_mode),
    .o_mode(startup_mode)
  );

  function automatic logic tool_allowed(input cmm_mode_t m, input logic [2:0] c);
    unique case (m)
      CMM_EDIT: tool_allowed = 1'b1;
      CMM_DEBUG: tool_allowed = (c != CMM_CMD_PARAM) && (c != CMM_CMD_PROGRAM);
      default: tool_allowed = (c == CMM_CMD_MONITOR);
    endcase
  endfunction

  // Only the tool reaches the store; a program attempt has no write path and cannot veto it
  assign tool_pstore_wr = i_tool_valid && i_tool_cmd == CMM_CMD_PARAM && mode == CMM_EDIT
    && !init_busy;

  // Parameter store is not cleared by reset: it is non-volatile
  always_ff @(posedge i_clk) begin
    if (tool_pstore_wr) begin
      startup_mode_setting <= i_pstore_wdata;
    end
  end

  // Retained mode is not reset; it models battery-backed storage
  always_ff @(posedge i_clk) begin
    if (!i_srst && !init_busy) begin
      retained_mode <= mode;
    end
  end

  // Startup word is sampled once at power-on, new values apply next power cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      init_busy <= 1'b1;
      clr_idx <= 4'h0;
      mode <= CMM_RUN;
    end else if (init_busy) begin
      clr_idx <= clr_idx + 4'h1;
      if (clr_idx == CMM_CLEAR_LAST) begin
        init_busy <= 1'b0;
        mode <= startup_mode;
      end
    end else if (req_s2 && prog_s2) begin
      mode <= req_val_s2;
    end
  end

  assign running = !init_busy && mode != CMM_EDIT;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mode <= CMM_RUN;
      o_exec_main <= 1'b0;
      o_exec_irq <= 1'b0;
      o_io_refresh <= 1'b0;
      o_tool_accept <= 1'b0;
      o_tool_reject <= 1'b0;
      o_pstore_we <= 1'b0;
      o_use_stored_comm <= 1'b0;
      o_init_busy <= 1'b1;
      o_clear_word <= 4'h0;
      o_clear_we <= 1'b0;
      o_startup_mode_setting <= CMM_STARTUP_WORD_RESET;
    end else begin
      o_mode <= mode;
      o_exec_main <= running && i_cycle_tick;
      o_exec_irq <= running && irq_s2;
      o_io_refresh <= !init_busy && i_cycle_tick;
      o_tool_accept <= i_tool_valid && !init_busy && tool_allowed(mode, i_tool_cmd);
      o_tool_reject <= i_tool_valid && (init_busy || !tool_allowed(mode, i_tool_cmd));
      o_pstore_we <= tool_pstore_wr;
      o_use_stored_comm <= comm_s2;
      o_init_busy <= init_busy;
      o_clear_word <= clr_idx;
      o_clear_we <= init_busy && !CMM_RETAIN_MASK[clr_idx];
      o_startup_mode_setting <= startup_mode_setting;
    end
  end

  // Last edge of the power-on walk, with the upper startup field at a given code
  sequence s_boot_last(logic [7:0] up);
    init_busy && clr_idx == CMM_CLEAR_LAST
      && startup_mode_setting[CMM_UPPER_LSB +: 8] == up;
  endsequence

  sequence s_walk;
    init_busy && clr_idx != CMM_CLEAR_LAST;
  endsequence

  sequence s_tool_cmd(logic [2:0] c);
    i_tool_valid && !init_busy && i_tool_cmd == c;
  endsequence

  a_edit_no_exec: assert property (@(posedge i_clk) disable iff (i_srst)
    o_mode == CMM_EDIT |-> !o_exec_main) else $error("program ran in edit");
  a_edit_refresh: assert property (@(posedge i_clk) disable iff (i_srst)
    (!init_busy && i_cycle_tick) |=> o_io_refresh) else $error("no refresh");
  a_edit_accept: assert property (@(posedge i_clk) disable iff (i_srst)
    (!init_busy && mode == CMM_EDIT && i_tool_valid) |=> o_tool_accept)
    else $error("edit refused tool");
  a_edit_store: assert property (@(posedge i_clk) disable iff (i_srst)
    s_tool_cmd(CMM_CMD_PARAM) ##0 (mode == CMM_EDIT) |=> o_pstore_we)
    else $error("edit lost store write");
  a_debug_force: assert property (@(posedge i_clk) disable iff (i_srst)
    s_tool_cmd(CMM_CMD_FORCE) ##0 (mode == CMM_DEBUG) |=> o_tool_accept)
    else $error("debug refused force");
  a_debug_value: assert property (@(posedge i_clk) disable iff (i_srst)
    s_tool_cmd(CMM_CMD_VALUE) ##0 (mode == CMM_DEBUG) |=> o_tool_accept)
    else $error("debug refused value change");
  a_run_reject: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode == CMM_RUN && i_tool_valid && i_tool_cmd != CMM_CMD_MONITOR)
    |=> o_tool_reject && !o_tool_accept) else $error("run took edit");
  a_run_monitor: assert property (@(posedge i_clk) disable iff (i_srst)
    s_tool_cmd(CMM_CMD_MONITOR) ##0 (mode == CMM_RUN) |=> o_tool_accept)
    else $error("run refused monitor");
  a_prog_no_write: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_prog_pstore_wr && !tool_pstore_wr) |=> !o_pstore_we)
    else $error("program wrote store");
  a_store_keeps_mode: assert property (@(posedge i_clk) disable iff (i_srst)
    (tool_pstore_wr && !(req_s2 && prog_s2)) |=> $stable(mode))
    else $error("store write moved mode");
  a_walk_holds: assert property (@(posedge i_clk) disable iff (i_srst)
    s_walk |=> init_busy && mode == CMM_RUN) else $error("mode left run during walk");
  a_retain_kept: assert property (@(posedge i_clk) disable iff (i_srst)
    o_clear_we |-> !CMM_RETAIN_MASK[o_clear_word]) else $error("retained cleared");
  a_comm_follow: assert property (@(posedge i_clk) disable iff (i_srst)
    comm_s2 |=> o_use_stored_comm) else $error("comm select lost");
  a_switch_start: assert property (@(posedge i_clk) disable iff (i_srst)
    s_boot_last(CMM_UP_SWITCH) ##0 prog_s2 |=> mode == switch_s2)
    else $error("switch mode not used");
  a_restore_prev: assert property (@(posedge i_clk) disable iff (i_srst)
    s_boot_last(CMM_UP_PREVIOUS) |=> mode == retained_mode) else $error("previous mode lost");
  a_lower_debug: assert property (@(posedge i_clk) disable iff (i_srst)
    s_boot_last(CMM_UP_LOWER) ##0 (startup_mode_setting[CMM_LOWER_LSB +: 8] == CMM_LO_DEBUG)
    |=> mode == CMM_DEBUG) else $error("lower field ignored");
  a_lower_edit: assert property (@(posedge i_clk) disable iff (i_srst)
    s_boot_last(CMM_UP_LOWER) ##0 (startup_mode_setting[CMM_LOWER_LSB +: 8] == CMM_LO_EDIT)
    |=> mode == CMM_EDIT) else $error("lower edit code lost");
  a_default_run: assert property (@(posedge i_clk) disable iff (i_srst)
    s_boot_last(CMM_UP_SWITCH) ##0 !prog_s2 |=> mode == CMM_RUN)
    else $error("default not run");
  a_main_cycle: assert property (@(posedge i_clk) disable iff (i_srst)
    (running && i_cycle_tick) |=> o_exec_main) else $error("main program skipped");
  a_irq_only: assert property (@(posedge i_clk) disable iff (i_srst)
    !irq_s2 |=> !o_exec_irq) else $error("interrupt program without interrupt");
  a_retain_track: assert property (@(posedge i_clk) disable iff (i_srst)
    !init_busy |=> retained_mode == $past(mode)) else $error("mode not retained");
endmodule

// >>> test/cmm_tool_model.sv
/*
  Programming tool and handheld programmer model: one-cycle command pulses.
  Assumes the controller takes commands on the rising clock edge.
*/
`timescale 1ns/1ns
module cmm_tool_model
  import cmm_pkg::*;
(
  input wire logic i_clk,
  output logic o_valid,
  output logic [2:0] o_cmd,
  output logic o_present
);
  initial begin
    o_valid = 1'b0;
    o_cmd = 3'h7;
    o_present = 1'b0;
  end
  // Code flips when idle so a stale value is never mistaken for a command
  task automatic send(input logic [2:0] c);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_cmd = c;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_cmd = ~c;
  endtask
endmodule

// >>> test/tb_top.sv
/*
  Self-checking bench: startup mode decode, tool gating, execution gating, clearing.
  Assumes the tool model drives the command and presence inputs.
*/
`timescale 1ns/1ns
module tb_top;
  import cmm_pkg::*;
  logic i_clk = 1'b0, i_srst = 1'b1, i_mode_req = 1'b0, i_prog_pstore_wr = 1'b0;
  logic i_comm_select = 1'b0, i_irq = 1'b0, i_cycle_tick = 1'b0;
  logic i_tool_valid, i_prog_present, o_exec_main, o_exec_irq, o_io_refresh;
  logic o_tool_accept, o_tool_reject, o_pstore_we, o_use_stored_comm, o_init_busy, o_clear_we;
  logic [2:0] i_tool_cmd;
  logic [3:0] o_clear_word;
  logic [15:0] i_pstore_wdata = 16'h0000, o_startup_mode_setting;
  cmm_mode_t i_switch_mode = CMM_RUN, i_mode_req_val = CMM_EDIT, o_mode, md;
  int miscompares = 0, n_compared = 0, seed = 32'h518e, acc, rej, we, ex, xi, rf, clr, bad;
  cmm_tool_model u_cmm_tool_model (.i_clk(i_clk), .o_valid(i_tool_valid),
    .o_cmd(i_tool_cmd), .o_present(i_prog_present));
  cmm_mode_manager u_cmm_mode_manager (.*);
  always #50 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    i_cycle_tick <= 1'($random(seed));
    i_irq <= 1'($random(seed));
    i_prog_pstore_wr <= 1'($random(seed));
  end
  always @(posedge i_clk) begin
    #1;
    ex += int'(o_exec_main === 1'b1);
    xi += int'(o_exec_irq === 1'b1);
    rf += int'(o_io_refresh === 1'b1);
    clr += int'(o_clear_we === 1'b1);
    bad += int'(o_clear_we === 1'b1 && o_clear_word[3] !== 1'b0);
  end
  task automatic check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic boot();
    i_srst = 1'b1;
    cyc(2);
    clr = 0;
    bad = 0;
    i_srst = 1'b0;
    for (int k = 0; k < 40 && o_init_busy !== 1'b0; k++) cyc(1);
    cyc(3);
  endtask
  task automatic to_mode(input cmm_mode_t m);
    u_cmm_tool_model.o_present = 1'b1;
    i_mode_req_val = m;
    i_mode_req = 1'b1;
    cyc(6);
    i_mode_req = 1'b0;
    cyc(2);
  endtask
  task automatic tool_cmd(input cmm_mode_t m, input logic [2:0] c);
    logic ok;
    ok = (m == CMM_EDIT) || (c == CMM_CMD_MONITOR) || (m == CMM_DEBUG && c < CMM_CMD_PARAM);
    acc = 0;
    rej = 0;
    we = 0;
    fork
      u_cmm_tool_model.send(c);
      repeat (4) begin
        @(posedge i_clk);
        #1;
        acc += int'(o_tool_accept === 1'b1);
        rej += int'(o_tool_reject === 1'b1);
        we += int'(o_pstore_we === 1'b1);
      end
    join
    check(16'(acc), {15'h0, ok});
    check(16'(rej), {15'h0, !ok});
    check(16'(we), {15'h0, m == CMM_EDIT && c == CMM_CMD_PARAM});
  endtask
  // The mode before power loss is set apart from run so a restore can be told from a default
  task automatic boot_case(input logic [15:0] w, input logic pr, input cmm_mode_t sw, pre, ex_m);
    to_mode(CMM_EDIT);
    i_pstore_wdata = w;
    u_cmm_tool_model.send(CMM_CMD_PARAM);
    cyc(2);
    check(o_startup_mode_setting, w);
    check(16'(o_mode), 16'(CMM_EDIT));
    to_mode(pre);
    u_cmm_tool_model.o_present = pr;
    i_switch_mode = sw;
    boot();
    check(16'(o_mode), 16'(ex_m));
  endtask
  task automatic final_report();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  initial begin
    boot();
    check(16'(clr), 16'h8);
    check(16'(bad), 16'h0);
    for (int i = 0; i < 3; i++) begin
      md = cmm_mode_t'(3'h1 << i);
      to_mode(md);
      ex = 0;
      xi = 0;
      rf = 0;
      for (int c = 0; c < 6; c++) tool_cmd(md, 3'(c));
      check(16'(ex > 0), 16'(md != CMM_EDIT));
      check(16'(xi > 0), 16'(md != CMM_EDIT));
      check(16'(rf > 0), 16'h1);
    end
    i_comm_select = 1'b1;
    cyc(4);
    check(16'(o_use_stored_comm), 16'h1);
    i_comm_select = 1'b0;
    cyc(4);
    check(16'(o_use_stored_comm), 16'h0);
    boot_case(16'h0200, 1'b0, CMM_RUN, CMM_RUN, CMM_EDIT);
    boot_case(16'h0201, 1'b0, CMM_RUN, CMM_EDIT, CMM_DEBUG);
    boot_case(16'h0202, 1'b1, CMM_EDIT, CMM_DEBUG, CMM_RUN);
    boot_case(16'h0000, 1'b1, CMM_DEBUG, CMM_RUN, CMM_DEBUG);
    boot_case(16'h0000, 1'b0, CMM_EDIT, CMM_EDIT, CMM_RUN);
    boot_case(16'h0100, 1'b0, CMM_RUN, CMM_DEBUG, CMM_DEBUG);
    final_report();
  end
endmodule
